// File: pkg/wrsc_pkg.sv
package wrsc_pkg;

	// Register byte offsets.
	localparam logic [7:0] WRSC_OFS_CTRL   = 8'h00;
	localparam logic [7:0] WRSC_OFS_DCONST = 8'h04;
	localparam logic [7:0] WRSC_OFS_DSCALE = 8'h08;
	localparam logic [7:0] WRSC_OFS_RMIN   = 8'h0C;
	localparam logic [7:0] WRSC_OFS_RMAX   = 8'h10;
	localparam logic [7:0] WRSC_OFS_STCMD  = 8'h14;
	localparam logic [7:0] WRSC_OFS_STSTAT = 8'h18;
	localparam logic [7:0] WRSC_OFS_PIXCNT = 8'h1C;
	localparam logic [7:0] WRSC_OFS_THRCNT = 8'h20;
	localparam logic [7:0] WRSC_OFS_ACTIVE = 8'h24;

	// Control word field positions.
	// Statistics enable takes a spare bit so it stays apart from 8-pixel dispatch.
	localparam int WRSC_B_STATS    = 9;
	localparam int WRSC_B_PIX8     = 0;
	localparam int WRSC_B_PIX16    = 1;
	localparam int WRSC_B_PIX32    = 2;
	localparam int WRSC_B_DBLEGACY = 10;
	localparam int WRSC_B_LSTIP    = 11;
	localparam int WRSC_B_DOFS     = 12;
	localparam int WRSC_B_PSTIP    = 13;
	localparam int WRSC_F_LAAW_LO  = 14;
	localparam int WRSC_F_CAPW_LO  = 16;
	localparam int WRSC_B_EARLYZ   = 18;
	localparam int WRSC_B_DISPATCH = 19;
	localparam int WRSC_B_SRCDEPTH = 20;
	localparam int WRSC_B_CDEPTH   = 21;
	localparam int WRSC_B_KILL     = 22;
	localparam int WRSC_B_LEGLINE  = 23;
	localparam int WRSC_F_MAXT_LO  = 25;

	// Dispatch, early depth and 16-pixel dispatch enabled out of reset.
	localparam logic [31:0] WRSC_CTRL_RST = 32'h000C_0002;

	// Stipple command header fields.
	localparam logic [2:0] WRSC_HDR_TYPE    = 3'h3;
	localparam logic [1:0] WRSC_HDR_SUBTYPE = 2'h3;
	localparam logic [2:0] WRSC_HDR_OPCODE  = 3'h1;
	localparam logic [7:0] WRSC_HDR_SUBOP   = 8'h08;
	localparam logic [7:0] WRSC_HDR_LEN     = 8'h01;
	localparam int WRSC_W1_MODIFY = 31;
	localparam int WRSC_W1_RCNT_LO = 21;
	localparam int WRSC_W1_SIDX_LO = 16;
	localparam int WRSC_W2_INV_LO = 16;
	localparam logic [8:0] WRSC_REP_RST = 9'h001;

	// Subspans per payload in each dispatch mode.
	localparam logic [3:0] WRSC_SS_32PX = 4'h8;
	localparam logic [3:0] WRSC_SS_16PX = 4'h4;
	localparam logic [3:0] WRSC_SS_8PX  = 4'h2;

	typedef enum logic [1:0] {WRSC_CMD_HDR, WRSC_CMD_PAT, WRSC_CMD_REP} wrsc_cmd_type;

endpackage

// File: rtl/wrsc_windower.sv
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Function
// RQ1 - Statistics counters advance only when enabled.
// RQ2 - Active threads limited to field plus one.
// RQ3 - Legacy diamond bit selects zero-width line rules.
// RQ4 - Software sets kill bit when shader discards.
// RQ5 - Computed depth disables early depth/stencil test.
// RQ6 - Source depth placed in payload when required.
// RQ7 - Dispatch enable clear dispatches no threads.
// RQ8 - Early depth bit enables intermediate depth test.
// RQ9 - End cap width codes give 0.5-4 pixels.
// RQ10 - Line width codes give 0.5-4 pixels.
// RQ11 - Polygon stipple masking has one enable.
// RQ12 - Global depth offset has one enable.
// RQ13 - Line stipple discard has one enable.
// RQ14 - Legacy bias bit passes offset constant unmodified.
// RQ15 - Dispatch modes of 8, 4, 2 subspans.
// RQ16 - Pixels handled as numbered 2x2 subspans.
// RQ17 - Unconditional inclusive drawing rectangle clipping.
// RQ18 - Line stipple only for non-antialiased lines.
// RQ19 - Stipple counter from zero, reset per primitive/segment.
// RQ20 - Render pixel only when pattern bit set.
// RQ21 - Stipple command header type, opcodes, length fixed.
// RQ22 - Software never sets the counter modify bit.
// RQ23 - Stipple words carry pattern and repeat counts.
// RQ24 - Pattern index is counter over repeat, mod 16.
module wrsc_windower
	import wrsc_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic        IN_VALID,
	output logic             IN_READY,
	input  wire logic [15:0] IN_X,
	input  wire logic [15:0] IN_Y,
	input  wire logic [3:0]  IN_MASK,
	input  wire logic [31:0] IN_DEPTH,
	input  wire logic        IN_LINE,
	input  wire logic        IN_AA,
	input  wire logic        IN_PRIM_START,
	input  wire logic        IN_PRIM_CONT,
	input  wire logic        IN_SEG_START,
	input  wire logic        IN_PRIM_END,
	input  wire logic [3:0]  IN_PSTIP_MASK,
	input  wire logic [3:0]  IN_IZ_FAIL,
	input  wire logic        THREAD_DONE,
	output logic             OUT_VALID,
	output logic             OUT_FIRST,
	output logic             OUT_LAST,
	output logic      [15:0] OUT_X,
	output logic      [15:0] OUT_Y,
	output logic      [3:0]  OUT_MASK,
	output logic      [31:0] OUT_DEPTH,
	output logic             OUT_KILL_EN,
	output logic             EARLY_TEST_ON,
	output logic             LEGACY_LINE_RULES,
	output logic      [3:0]  LINE_AA_WIDTH,
	output logic      [3:0]  CAP_AA_WIDTH,
	output logic             DEPTH_OFS_EN,
	output logic             DEPTH_OFS_LEGACY,
	output logic      [31:0] DEPTH_OFS_CONST,
	output logic      [31:0] DEPTH_OFS_SCALE
);

	////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [31:0]  ctrl;
		logic [31:0]  dconst;
		logic [31:0]  dscale;
		logic [31:0]  rmin;
		logic [31:0]  rmax;
		logic [15:0]  pattern;
		logic [8:0]   rep;
		logic [15:0]  inv_rep;
		logic [8:0]   rcnt;
		logic [3:0]   sidx;
		wrsc_cmd_type cmd;
		logic [31:0]  pix_stat;
		logic [31:0]  thr_stat;
		logic [7:0]   active;
		logic         open;
		logic [3:0]   fill;
		logic         out_valid;
		logic         out_first;
		logic         out_last;
		logic [15:0]  out_x;
		logic [15:0]  out_y;
		logic [3:0]   out_mask;
		logic [31:0]  out_depth;
		logic [31:0]  rdata;
	} wrsc_state_type;

	localparam wrsc_state_type WRSC_STATE_RST = '{
		ctrl: WRSC_CTRL_RST,
		rep: WRSC_REP_RST,
		cmd: WRSC_CMD_HDR,
		default: '0
	};

	wrsc_state_type s_q;
	wrsc_state_type s_d;

	logic [3:0] mask_c;
	logic [3:0] size_c;
	logic       stall_c;

	////////////////////////////////////////////////////////////////////////////

	// Maps a two-bit width code to a width in half-pixel units.
	function automatic logic [3:0] wrsc_width(input logic [1:0] code);
		wrsc_width = 4'h1 << code; // [RQ9] [RQ10]
	endfunction

	always_comb begin
		if (s_q.ctrl[WRSC_B_PIX32]) begin
			size_c = WRSC_SS_32PX; // [RQ15]
		end else if (s_q.ctrl[WRSC_B_PIX16]) begin
			size_c = WRSC_SS_16PX;
		end else if (s_q.ctrl[WRSC_B_PIX8]) begin
			size_c = WRSC_SS_8PX;
		end else begin
			size_c = WRSC_SS_16PX;
		end
	end

	// A subspan that would open a payload waits while every thread slot is busy.
	// The stall is taken even for subspans that later turn out empty, which
	// costs a little throughput but keeps the ready free of the mask logic.
	assign stall_c = !s_q.open
		&& (s_q.active > {1'b0, s_q.ctrl[WRSC_F_MAXT_LO +: 7]}); // [RQ2]
	assign IN_READY = !stall_c;

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic        take;
		logic        iz_on;
		logic        stip_on;
		logic        emit;
		logic        last;
		logic [16:0] px;
		logic [16:0] py;
		logic [8:0]  rc;
		logic [3:0]  ix;
		logic [2:0]  npix;
		take = IN_VALID && IN_READY;
		iz_on = s_q.ctrl[WRSC_B_EARLYZ] && !s_q.ctrl[WRSC_B_CDEPTH]; // [RQ8] [RQ5]
		stip_on = s_q.ctrl[WRSC_B_LSTIP] && IN_LINE && !IN_AA; // [RQ13] [RQ18]
		emit = 1'b0;
		last = 1'b0;
		px = '0;
		py = '0;
		npix = '0;
		rc = s_q.rcnt;
		ix = s_q.sidx;
		s_d = s_q;
		s_d.out_valid = 1'b0;
		s_d.out_first = 1'b0;
		s_d.out_last = 1'b0;
		s_d.rdata = '0;
		mask_c = IN_MASK;

		// Pixel k of a subspan sits at column k[0] and row k[1].
		for (int k = 0; k < 4; k++) begin
			px = {1'b0, IN_X} + {16'h0000, k[0]}; // [RQ16]
			py = {1'b0, IN_Y} + {16'h0000, k[1]};
			if (px < {1'b0, s_q.rmin[15:0]} || px > {1'b0, s_q.rmax[15:0]}
				|| py < {1'b0, s_q.rmin[31:16]} || py > {1'b0, s_q.rmax[31:16]}) begin
				mask_c[k] = 1'b0; // [RQ17]
			end
		end
		if (s_q.ctrl[WRSC_B_PSTIP] && !IN_LINE) begin
			mask_c = mask_c & IN_PSTIP_MASK; // [RQ11]
		end
		if (iz_on) begin
			mask_c = mask_c & ~IN_IZ_FAIL;
		end

		// The counter is kept as a repeat count and a pattern index, so no
		// divider is needed; line pixels are taken to run in order 0 to 3.
		if ((IN_PRIM_START && !IN_PRIM_CONT) || IN_SEG_START) begin
			rc = '0; // [RQ19]
			ix = '0;
		end
		for (int k = 0; k < 4; k++) begin
			if (IN_LINE && IN_MASK[k]) begin
				if (stip_on && !s_q.pattern[ix]) begin
					mask_c[k] = 1'b0; // [RQ20]
				end
				if (rc + 9'h001 >= s_q.rep) begin
					rc = '0; // [RQ24]
					ix = ix + 4'h1;
				end else begin
					rc = rc + 9'h001; // [RQ19]
				end
			end
		end
		if (!s_q.ctrl[WRSC_B_DISPATCH]) begin
			mask_c = '0; // [RQ7]
		end

		if (take) begin
			s_d.rcnt = rc;
			s_d.sidx = ix;
			emit = (mask_c != 4'h0) || (IN_PRIM_END && s_q.open);
			last = IN_PRIM_END || (s_q.fill + 4'h1 >= size_c); // [RQ15]
		end
		for (int k = 0; k < 4; k++) begin
			npix = npix + {2'b00, mask_c[k] & emit};
		end

		if (emit) begin
			s_d.out_valid = 1'b1;
			s_d.out_first = !s_q.open;
			s_d.out_last = last;
			s_d.out_x = IN_X;
			s_d.out_y = IN_Y;
			s_d.out_mask = mask_c;
			s_d.out_depth = s_q.ctrl[WRSC_B_SRCDEPTH] ? IN_DEPTH : 32'h0000_0000; // [RQ6]
			s_d.open = !last;
			s_d.fill = last ? 4'h0 : s_q.fill + 4'h1;
		end
		s_d.active = s_q.active + {7'h00, emit && !s_q.open}
			- {7'h00, THREAD_DONE && (s_q.active != 8'h00)}; // [RQ2]
		if (s_q.ctrl[WRSC_B_STATS]) begin
			s_d.pix_stat = s_q.pix_stat + {29'h0, npix}; // [RQ1]
			s_d.thr_stat = s_q.thr_stat + {31'h0, emit && !s_q.open};
		end

		////////////////////////////////////////////////////////////////////////

		if (WR) begin
			case (ADDR)
				WRSC_OFS_CTRL: begin
					s_d.ctrl = WDATA; // [RQ3] [RQ12] [RQ14]
				end
				WRSC_OFS_DCONST: begin
					s_d.dconst = WDATA;
				end
				WRSC_OFS_DSCALE: begin
					s_d.dscale = WDATA;
				end
				WRSC_OFS_RMIN: begin
					s_d.rmin = WDATA;
				end
				WRSC_OFS_RMAX: begin
					s_d.rmax = WDATA;
				end
				WRSC_OFS_STCMD: begin
					case (s_q.cmd)
						WRSC_CMD_HDR: begin
							if (WDATA[31:29] == WRSC_HDR_TYPE
								&& WDATA[28:27] == WRSC_HDR_SUBTYPE
								&& WDATA[26:24] == WRSC_HDR_OPCODE
								&& WDATA[23:16] == WRSC_HDR_SUBOP
								&& WDATA[7:0] == WRSC_HDR_LEN) begin
								s_d.cmd = WRSC_CMD_PAT; // [RQ21]
							end
						end
						WRSC_CMD_PAT: begin
							s_d.pattern = WDATA[15:0]; // [RQ23]
							// Only context restore sets this; it reloads the counter.
							if (WDATA[WRSC_W1_MODIFY]) begin
								s_d.rcnt = WDATA[WRSC_W1_RCNT_LO +: 9]; // [RQ22]
								s_d.sidx = WDATA[WRSC_W1_SIDX_LO +: 4];
							end
							s_d.cmd = WRSC_CMD_REP;
						end
						WRSC_CMD_REP: begin
							s_d.rep = WDATA[8:0]; // [RQ23]
							s_d.inv_rep = WDATA[WRSC_W2_INV_LO +: 16];
							s_d.cmd = WRSC_CMD_HDR;
						end
						default: begin
							s_d.cmd = WRSC_CMD_HDR;
						end
					endcase
				end
				WRSC_OFS_PIXCNT: begin
					s_d.pix_stat = WDATA;
				end
				WRSC_OFS_THRCNT: begin
					s_d.thr_stat = WDATA;
				end
				default: begin
				end
			endcase
		end

		if (RD) begin
			case (ADDR)
				WRSC_OFS_CTRL:   s_d.rdata = s_q.ctrl;
				WRSC_OFS_DCONST: s_d.rdata = s_q.dconst;
				WRSC_OFS_DSCALE: s_d.rdata = s_q.dscale;
				WRSC_OFS_RMIN:   s_d.rdata = s_q.rmin;
				WRSC_OFS_RMAX:   s_d.rdata = s_q.rmax;
				WRSC_OFS_STCMD:  s_d.rdata = {s_q.inv_rep, 7'h00, s_q.rep};
				WRSC_OFS_STSTAT: s_d.rdata = {3'h0, s_q.rcnt, s_q.sidx, s_q.pattern};
				WRSC_OFS_PIXCNT: s_d.rdata = s_q.pix_stat;
				WRSC_OFS_THRCNT: s_d.rdata = s_q.thr_stat;
				WRSC_OFS_ACTIVE: s_d.rdata = {22'h0, s_q.cmd, s_q.active};
				default:         s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			s_q <= WRSC_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	assign RDATA = s_q.rdata;
	assign OUT_VALID = s_q.out_valid;
	assign OUT_FIRST = s_q.out_first;
	assign OUT_LAST = s_q.out_last;
	assign OUT_X = s_q.out_x;
	assign OUT_Y = s_q.out_y;
	assign OUT_MASK = s_q.out_mask;
	assign OUT_DEPTH = s_q.out_depth;
	// The kernel promises no discards while this is low; nothing here checks it.
	assign OUT_KILL_EN = s_q.ctrl[WRSC_B_KILL]; // [RQ4]
	assign EARLY_TEST_ON = s_q.ctrl[WRSC_B_EARLYZ] && !s_q.ctrl[WRSC_B_CDEPTH]; // [RQ5] [RQ8]
	assign LEGACY_LINE_RULES = s_q.ctrl[WRSC_B_LEGLINE]; // [RQ3]
	assign LINE_AA_WIDTH = wrsc_width(s_q.ctrl[WRSC_F_LAAW_LO +: 2]); // [RQ10]
	assign CAP_AA_WIDTH = wrsc_width(s_q.ctrl[WRSC_F_CAPW_LO +: 2]); // [RQ9]
	assign DEPTH_OFS_EN = s_q.ctrl[WRSC_B_DOFS]; // [RQ12]
	assign DEPTH_OFS_LEGACY = s_q.ctrl[WRSC_B_DBLEGACY]; // [RQ14]
	assign DEPTH_OFS_CONST = s_q.dconst;
	assign DEPTH_OFS_SCALE = s_q.dscale;

endmodule

// File: tb/wrsc_chk.sv
`timescale 1ns/1ps
module wrsc_chk
	import wrsc_pkg::*;
(
	input wire logic        CLK,
	input wire logic        NRST,
	input wire logic [7:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        IN_VALID,
	input wire logic        IN_READY,
	input wire logic        IN_PRIM_END,
	input wire logic        OUT_VALID,
	input wire logic        OUT_LAST,
	input wire logic [31:0] OUT_DEPTH,
	input wire logic        OUT_KILL_EN,
	input wire logic        EARLY_TEST_ON,
	input wire logic        LEGACY_LINE_RULES,
	input wire logic [3:0]  LINE_AA_WIDTH,
	input wire logic [3:0]  CAP_AA_WIDTH,
	input wire logic        DEPTH_OFS_EN,
	input wire logic        DEPTH_OFS_LEGACY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	logic [31:0] ctrl_q;
	// Mirror of the control word, so checks do not trust the design's copy.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			ctrl_q <= WRSC_CTRL_RST;
		else if (WR && ADDR == WRSC_OFS_CTRL)
			ctrl_q <= WDATA;
	end
	sequence s_ctrl_wr;
		WR && ADDR == WRSC_OFS_CTRL;
	endsequence
	sequence s_take;
		IN_VALID && IN_READY;
	endsequence
	sequence s_end_take;
		IN_VALID && IN_READY && IN_PRIM_END;
	endsequence
	a_early_test: assert property (EARLY_TEST_ON ==
		(ctrl_q[WRSC_B_EARLYZ] && !ctrl_q[WRSC_B_CDEPTH]))
		else $error("early test enable wrong");
	a_line_rules: assert property (s_ctrl_wr |=>
		LEGACY_LINE_RULES == $past(WDATA[WRSC_B_LEGLINE]))
		else $error("line rules wrong");
	a_line_width: assert property (s_ctrl_wr |=>
		LINE_AA_WIDTH == (4'h1 << $past(WDATA[WRSC_F_LAAW_LO +: 2])))
		else $error("line width wrong");
	a_cap_width: assert property (s_ctrl_wr |=>
		CAP_AA_WIDTH == (4'h1 << $past(WDATA[WRSC_F_CAPW_LO +: 2])))
		else $error("cap width wrong");
	a_flag_bits: assert property (s_ctrl_wr |=> {OUT_KILL_EN, DEPTH_OFS_EN, DEPTH_OFS_LEGACY}
		== {$past(WDATA[WRSC_B_KILL]), $past(WDATA[WRSC_B_DOFS]),
		$past(WDATA[WRSC_B_DBLEGACY])})
		else $error("flag bits wrong");
	a_no_dispatch: assert property (!ctrl_q[WRSC_B_DISPATCH] ##0 s_take |=> !OUT_VALID)
		else $error("dispatch while disabled");
	a_out_cause: assert property (OUT_VALID |-> $past(IN_VALID) && $past(IN_READY))
		else $error("output without take");
	a_prim_last: assert property (s_end_take ##1 OUT_VALID |-> OUT_LAST)
		else $error("primitive end not last");
	a_depth_zero: assert property (OUT_VALID && !$past(ctrl_q[WRSC_B_SRCDEPTH]) |-> OUT_DEPTH == 32'h0)
		else $error("depth not zero");
endmodule
bind wrsc_windower wrsc_chk chk_u (.CLK, .NRST, .ADDR, .WDATA, .WR, .IN_VALID, .IN_READY,
	.IN_PRIM_END, .OUT_VALID, .OUT_LAST, .OUT_DEPTH, .OUT_KILL_EN, .EARLY_TEST_ON,
	.LEGACY_LINE_RULES, .LINE_AA_WIDTH, .CAP_AA_WIDTH, .DEPTH_OFS_EN, .DEPTH_OFS_LEGACY);

// File: tb/wrsc_thr_model.sv
`timescale 1ns/1ps
module wrsc_thr_model
	import wrsc_pkg::*;
#(parameter int DELAY = 5)
(
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic stall,
	input  wire logic sub_valid,
	input  wire logic sub_first,
	output logic      thread_done
);
	int   open_q;
	int   tmr_q;
	logic done;
	// Threads never discard pixels, so a clear kill bit is always honest.
	assign done = open_q > 0 && tmr_q == 0 && !stall;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			open_q <= 0;
			tmr_q <= 0;
			thread_done <= 1'b0;
		end else begin
			thread_done <= done;
			open_q <= open_q + int'(sub_valid && sub_first) - int'(done);
			tmr_q <= done ? DELAY : (tmr_q > 0 ? tmr_q - 1 : 0);
		end
	end
endmodule

// File: tb/wrsc_windower_tb.sv
`timescale 1ns/1ps
module wrsc_windower_tb
	import wrsc_pkg::*;
;
	logic        CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, IN_VALID = 1'b0, stall = 1'b0;
	logic        IN_LINE = 1'b0, IN_AA = 1'b0, IN_PRIM_START = 1'b0, IN_PRIM_CONT = 1'b0;
	logic        IN_SEG_START = 1'b0, IN_PRIM_END = 1'b0, THREAD_DONE;
	logic [7:0]  ADDR = 8'h00;
	logic [15:0] IN_X = 16'h0, IN_Y = 16'h0;
	logic [15:0] OUT_X, OUT_Y, o_x, o_y;
	logic [3:0]  IN_MASK = 4'h0, IN_PSTIP_MASK = 4'h0, IN_IZ_FAIL = 4'h0;
	logic [31:0] WDATA = 32'h0, IN_DEPTH = 32'h1234_5678, RDATA, rdv, o_d;
	logic [31:0] OUT_DEPTH, DEPTH_OFS_CONST, DEPTH_OFS_SCALE;
	logic [3:0]  OUT_MASK, LINE_AA_WIDTH, CAP_AA_WIDTH, o_m;
	logic        IN_READY, OUT_VALID, OUT_FIRST, OUT_LAST, OUT_KILL_EN, EARLY_TEST_ON;
	logic        LEGACY_LINE_RULES, DEPTH_OFS_EN, DEPTH_OFS_LEGACY, o_v, o_f, o_l;
	int          n_mismatch = 0, cmp_count = 0;
	logic [31:0] c_ctrl [5] = '{32'h000C_0002, 32'h003C_0002, 32'h0008_0002, 32'h000C_2002,
		32'h0004_0002};
	logic [3:0]  c_exp [5] = '{4'hC, 4'hF, 4'hF, 4'h4, 4'h0};
	logic [5:0]  s_fl [4] = '{6'h28, 6'h2C, 6'h22, 6'h30};
	logic [3:0]  s_ex [4] = '{4'h5, 4'hC, 4'h5, 4'hF};
	always #4 CLK = ~CLK;
	wrsc_windower dut_u (.CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IN_VALID, .IN_READY,
		.IN_X, .IN_Y, .IN_MASK, .IN_DEPTH, .IN_LINE, .IN_AA, .IN_PRIM_START, .IN_PRIM_CONT,
		.IN_SEG_START, .IN_PRIM_END, .IN_PSTIP_MASK, .IN_IZ_FAIL, .THREAD_DONE, .OUT_VALID,
		.OUT_FIRST, .OUT_LAST, .OUT_X, .OUT_Y, .OUT_MASK, .OUT_DEPTH, .OUT_KILL_EN,
		.EARLY_TEST_ON, .LEGACY_LINE_RULES, .LINE_AA_WIDTH, .CAP_AA_WIDTH, .DEPTH_OFS_EN,
		.DEPTH_OFS_LEGACY, .DEPTH_OFS_CONST, .DEPTH_OFS_SCALE);
	wrsc_thr_model #(.DELAY(5)) thr_u (.clk(CLK), .nrst(NRST), .stall(stall),
		.sub_valid(OUT_VALID), .sub_first(OUT_FIRST), .thread_done(THREAD_DONE));
	////////////////////////////////////////////////////////////
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 rdv = RDATA;
	endtask
	// The bench drops valid for a cycle between subspans to keep each answer apart.
	task automatic send(logic [15:0] x, logic [5:0] f, logic [3:0] iz, logic [3:0] ps);
		int   n;
		logic r;
		n = 0;
		r = 1'b0;
		@(posedge CLK);
		IN_X <= x;
		IN_Y <= x;
		IN_MASK <= 4'hF;
		{IN_LINE, IN_AA, IN_PRIM_START, IN_PRIM_CONT, IN_SEG_START, IN_PRIM_END} <= f;
		IN_IZ_FAIL <= iz;
		IN_PSTIP_MASK <= ps;
		IN_VALID <= 1'b1;
		while (r !== 1'b1 && n < 200) begin
			#1 r = IN_READY;
			@(posedge CLK);
			n++;
		end
		IN_VALID <= 1'b0;
		if (r !== 1'b1) begin
			n_mismatch++;
			results();
		end
		#1 {o_v, o_f, o_l, o_m, o_d} = {OUT_VALID, OUT_FIRST, OUT_LAST, OUT_MASK, OUT_DEPTH};
		{o_x, o_y} = {OUT_X, OUT_Y};
	endtask
	initial begin
		#400000 n_mismatch++;
		results();
	end
	initial begin
		repeat (12) @(posedge CLK);
		NRST <= 1'b1;
		rd(WRSC_OFS_CTRL);
		chk("ctrl", WRSC_CTRL_RST, rdv);
		rd(8'h30);
		chk("unmapped", 32'h0, rdv);
		wr(WRSC_OFS_RMIN, 32'h0002_0002);
		wr(WRSC_OFS_RMAX, 32'h0003_0003);
		wr(WRSC_OFS_DCONST, 32'h3F80_0000);
		wr(WRSC_OFS_DSCALE, 32'h4000_0000);
		chk("dconst", 32'h3F80_0000, DEPTH_OFS_CONST);
		chk("dscale", 32'h4000_0000, DEPTH_OFS_SCALE);
		for (int i = 0; i < 4; i++) begin
			wr(WRSC_OFS_CTRL, 32'h000C_0002 | 32'(i) << 14 | 32'(i) << 16 | 32'(i % 2) * 32'h00C0_1400);
			chk("linew", 32'h1 << i, LINE_AA_WIDTH);
			chk("capw", 32'h1 << i, CAP_AA_WIDTH);
			chk("legacy", i % 2, LEGACY_LINE_RULES);
			chk("flags", (i % 2) * 7, {OUT_KILL_EN, DEPTH_OFS_EN, DEPTH_OFS_LEGACY});
		end
		for (int i = 0; i < 5; i++) begin
			wr(WRSC_OFS_CTRL, c_ctrl[i]);
			send(16'h2, 6'h09, 4'h3, 4'h6);
			chk("valid", c_exp[i] != 4'h0, o_v);
			chk("mask", c_exp[i], o_v ? o_m : 4'h0);
			chk("depth", c_ctrl[i][20] ? IN_DEPTH : 32'h0, o_d);
		end
		wr(WRSC_OFS_CTRL, 32'h000C_0002);
		send(16'h3, 6'h09, 4'h0, 4'h0);
		chk("clip hi", 4'h1, o_m);
		chk("out x", 32'h3, o_x);
		chk("out y", 32'h3, o_y);
		send(16'h1, 6'h09, 4'h0, 4'h0);
		chk("clip lo", 4'h8, o_m);
		wr(WRSC_OFS_PIXCNT, 32'h0);
		wr(WRSC_OFS_THRCNT, 32'h0);
		wr(WRSC_OFS_CTRL, 32'h000C_0202);
		send(16'h2, 6'h09, 4'h0, 4'h0);
		wr(WRSC_OFS_CTRL, 32'h000C_0002);
		send(16'h2, 6'h09, 4'h0, 4'h0);
		rd(WRSC_OFS_PIXCNT);
		chk("pixcnt", 32'h4, rdv);
		rd(WRSC_OFS_THRCNT);
		chk("thrcnt", 32'h1, rdv);
		for (int m = 0; m < 3; m++) begin
			wr(WRSC_OFS_CTRL, 32'h000C_0000 | 32'h1 << m);
			for (int k = 1; k <= (2 << m); k++) begin
				send(16'h2, k == 1 ? 6'h08 : 6'h00, 4'h0, 4'h0);
				chk("first", k == 1, o_f);
				chk("last", k == (2 << m), o_l);
			end
		end
		wr(WRSC_OFS_CTRL, 32'h020C_0002);
		repeat (20) @(posedge CLK);
		stall <= 1'b1;
		send(16'h2, 6'h09, 4'h0, 4'h0);
		send(16'h2, 6'h09, 4'h0, 4'h0);
		rd(WRSC_OFS_ACTIVE);
		chk("active", 32'h2, rdv & 32'hFF);
		chk("ready", 1'b0, IN_READY);
		@(posedge CLK);
		stall <= 1'b0;
		send(16'h2, 6'h09, 4'h0, 4'h0);
		chk("resume", 1'b1, o_v);
		wr(WRSC_OFS_CTRL, 32'h000C_0802);
		wr(WRSC_OFS_STCMD, 32'h7907_0001);
		rd(WRSC_OFS_ACTIVE);
		chk("badhdr", 32'h0, rdv & 32'h300);
		wr(WRSC_OFS_STCMD, 32'h7908_0001);
		rd(WRSC_OFS_ACTIVE);
		chk("hdr", 32'(WRSC_CMD_PAT) << 8, rdv & 32'h300);
		wr(WRSC_OFS_STCMD, 32'h0000_00C5);
		wr(WRSC_OFS_STCMD, 32'h2000_0001);
		rd(WRSC_OFS_STSTAT);
		chk("pattern", 32'h00C5, rdv & 32'hFFFF);
		rd(WRSC_OFS_STCMD);
		chk("repeat", 32'h2000_0001, rdv);
		for (int i = 0; i < 4; i++) begin
			send(16'h2, s_fl[i], 4'h0, 4'h0);
			chk("stipple", s_ex[i], o_m);
		end
		wr(WRSC_OFS_CTRL, 32'h000C_0002);
		send(16'h2, 6'h28, 4'h0, 4'h0);
		chk("stip off", 4'hF, o_m);
		wr(WRSC_OFS_CTRL, 32'h000C_0802);
		wr(WRSC_OFS_STCMD, 32'h7908_0001);
		wr(WRSC_OFS_STCMD, 32'h0000_0001);
		wr(WRSC_OFS_STCMD, 32'h1000_0002);
		send(16'h2, 6'h28, 4'h0, 4'h0);
		chk("rep2", 4'h3, o_m);
		// Stands in for a context restore, the only writer allowed to set the modify bit.
		wr(WRSC_OFS_STCMD, 32'h7908_0001);
		wr(WRSC_OFS_STCMD, 32'h8025_0020);
		wr(WRSC_OFS_STCMD, 32'h0000_0002);
		rd(WRSC_OFS_STSTAT);
		chk("restore", 32'h0015_0020, rdv);
		send(16'h2, 6'h2C, 4'h0, 4'h0);
		chk("resumed", 4'h1, o_m);
		results();
	end
endmodule
